// ==== hdl/ssm_deser.sv ====
// Purpose: 1:N deserializer with parallel clock, normal or double-rate
// Assumes: one offered bit per strobe, first bit lands in the word msb
// Notes: word and clock come straight from flip-flops
`timescale 1ns/1ns

module ssm_deser #(
  parameter int WIDTH = ssm_pkg::WORD_BITS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire ssm_pkg::ssm_serial_type serial_in,
  input wire logic double_rate,
  output logic [WIDTH-1:0] word,
  output logic word_valid,
  output logic par_clock
);

  localparam int IDX_BITS = $clog2(WIDTH);
  localparam logic [IDX_BITS-1:0] LAST_IDX = IDX_BITS'(WIDTH - 1);
  localparam logic [IDX_BITS-1:0] HALF_IDX = IDX_BITS'(WIDTH / 2);

  typedef struct packed {
    logic [WIDTH-1:0] shift;
    logic [IDX_BITS-1:0] index;
    logic [WIDTH-1:0] word;
    logic word_valid;
    logic par_clock;
  } ssm_deser_state_type;

  ssm_deser_state_type state;
  ssm_deser_state_type next_state;

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_state = state;
    next_state.word_valid = 1'b0;
    if (serial_in.strobe) begin
      next_state.shift = {state.shift[WIDTH-2:0], serial_in.value};
      if (state.index == LAST_IDX) begin
        next_state.index = '0;
        next_state.word = {state.shift[WIDTH-2:0], serial_in.value};
        next_state.word_valid = 1'b1;
      end else begin
        next_state.index = state.index + 1'b1;
      end
      if (double_rate) begin
        // one clock period spans two words, data on both edges
        next_state.par_clock = state.par_clock ^ (state.index == LAST_IDX);
      end else begin
        // divide by four: rises mid-word so the word is stable on the edge
        next_state.par_clock = (next_state.index >= HALF_IDX);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign word = state.word;
  assign word_valid = state.word_valid;
  assign par_clock = state.par_clock;

endmodule // ssm_deser

// ==== hdl/ssm_pkg.sv ====
// Purpose: shared constants and types of the serdes mode and loopback block
// Assumes: one bit of serial data per hclk cycle stands in for the serial clock
// Notes: register map sits on an AHB-Lite slave, one 32-bit word per register
package ssm_pkg;

  localparam int WORD_BITS = 4;
  localparam int ADDR_BITS = 8;
  localparam int COUNT_BITS = 16;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_OFFSET = 8'h08;

  // control word, rx_path_select_0 in bit 0 upward
  typedef struct packed {
    logic tx_rate_select_1;
    logic tx_rate_select_0;
    logic rx_rate_select_1;
    logic rx_rate_select_0;
    logic double_rate_select;
    logic tx_path_select_1;
    logic tx_path_select_0;
    logic rx_path_select_1;
    logic rx_path_select_0;
  } ssm_ctrl_type;

  localparam int CTRL_BITS = $bits(ssm_ctrl_type);
  // normal flow, divide-by-four clock, 2.5G down and 1.25G up rate selects
  localparam ssm_ctrl_type CTRL_RESET = 9'h16F;

  typedef struct packed {
    logic [18:0] zero;
    logic clock_recovered;
    logic [1:0] tx_mode;
    logic [1:0] rx_mode;
    logic [WORD_BITS-1:0] tx_word;
    logic [WORD_BITS-1:0] rx_word;
  } ssm_status_type;

  typedef struct packed {
    logic [COUNT_BITS-1:0] tx_words;
    logic [COUNT_BITS-1:0] rx_words;
  } ssm_count_type;

  // mode codes are {path_select_0, path_select_1}
  typedef enum logic [1:0] {
    RX_NORMAL_ALT = 2'b00,
    RX_CDR_BYPASS = 2'b01,
    RX_LOCAL_LOOP = 2'b10,
    RX_NORMAL = 2'b11
  } ssm_rx_mode_type;

  typedef enum logic [1:0] {
    TX_REMOTE_SERIAL = 2'b00,
    TX_REMOTE_DATA = 2'b01,
    TX_REMOTE_CLOCK = 2'b10,
    TX_NORMAL = 2'b11
  } ssm_tx_mode_type;

  typedef enum logic [1:0] {
    REG_CTRL = 2'b00,
    REG_STATUS = 2'b01,
    REG_COUNT = 2'b10,
    REG_NONE = 2'b11
  } ssm_reg_type;

  // one serial bit offered to the deserializer
  typedef struct packed {
    logic strobe;
    logic value;
  } ssm_serial_type;

  typedef struct packed {
    ssm_ctrl_type ctrl;
    ssm_reg_type data_reg;
    logic write_phase;
    logic [31:0] hrdata;
    logic hreadyout;
    logic ref_prev;
    logic tx_clock_prev;
    logic [WORD_BITS-1:0] tx_hold;
    logic [WORD_BITS-1:0] tx_shift;
    logic [$clog2(WORD_BITS)-1:0] tx_bit;
    logic secondary_clock;
    logic serial_out;
    logic rec_clock;
    logic rec_data;
    ssm_count_type counts;
  } ssm_top_state_type;

endpackage

// ==== hdl/ssm_top.sv ====
// Purpose: mode selection and data routing of a 4-bit serdes with loopbacks
// Assumes: one serial bit per hclk; pins are synchronous to hclk
// Notes: path and rate selects live in a control register on AHB-Lite
`timescale 1ns/1ns

module ssm_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic serial_data_in,
  input wire logic reference_clock,
  input wire logic tx_parallel_clock_in,
  input wire logic [ssm_pkg::WORD_BITS-1:0] tx_data_in,
  output logic serial_data_out,
  output logic [ssm_pkg::WORD_BITS-1:0] rx_data_out,
  output logic rx_parallel_clock_out,
  output logic secondary_parallel_clock_out
);

  localparam int WB = ssm_pkg::WORD_BITS;
  localparam int BIT_IDX = $clog2(WB);
  localparam logic [BIT_IDX-1:0] HALF_BIT = BIT_IDX'(WB / 2);
  localparam logic [ssm_pkg::COUNT_BITS-1:0] COUNT_ONE = 1;

  ssm_pkg::ssm_top_state_type state;
  ssm_pkg::ssm_top_state_type next_state;
  ssm_pkg::ssm_serial_type rx_serial;
  ssm_pkg::ssm_rx_mode_type rx_mode;
  ssm_pkg::ssm_tx_mode_type tx_mode;
  ssm_pkg::ssm_status_type status;
  logic [WB-1:0] rx_word;
  logic rx_word_valid;
  logic rx_par_clock;
  logic serializer_bit;
  logic bypass;
  logic ref_falling;
  logic tx_clock_rising;
  logic bus_request;

  //////////////////////////////////////////////////////////////////////////////
  // register decode, shared by the read and write sides

  function automatic ssm_pkg::ssm_reg_type decode_reg(input logic [31:0] addr);
    ssm_pkg::ssm_reg_type sel;
    sel = ssm_pkg::REG_NONE;
    if (addr[31:ssm_pkg::ADDR_BITS] == '0) begin
      unique case (addr[ssm_pkg::ADDR_BITS-1:0])
        ssm_pkg::CTRL_OFFSET: sel = ssm_pkg::REG_CTRL;
        ssm_pkg::STATUS_OFFSET: sel = ssm_pkg::REG_STATUS;
        ssm_pkg::COUNT_OFFSET: sel = ssm_pkg::REG_COUNT;
        default: sel = ssm_pkg::REG_NONE;
      endcase
    end
    return sel;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // mode decode and receive routing

  always_comb begin
    rx_mode = ssm_pkg::ssm_rx_mode_type'({state.ctrl.rx_path_select_0,
                                          state.ctrl.rx_path_select_1});
    tx_mode = ssm_pkg::ssm_tx_mode_type'({state.ctrl.tx_path_select_0,
                                          state.ctrl.tx_path_select_1});
    bypass = (rx_mode == ssm_pkg::RX_CDR_BYPASS);
    ref_falling = state.ref_prev & ~reference_clock;
    tx_clock_rising = ~state.tx_clock_prev & tx_parallel_clock_in;
    serializer_bit = state.tx_shift[WB-1];
    bus_request = hsel & hready & htrans[1];
  end

  always_comb begin
    rx_serial.strobe = 1'b1;
    rx_serial.value = serial_data_in;
    unique case (rx_mode)
      ssm_pkg::RX_NORMAL, ssm_pkg::RX_NORMAL_ALT: begin
        // recovered clock gives one bit per cycle; the reference clock is not used here
        rx_serial.strobe = 1'b1;
        rx_serial.value = serial_data_in;
      end
      ssm_pkg::RX_CDR_BYPASS: begin
        // no synthesizer: reference clock falling edges alone pace the bits
        rx_serial.strobe = ref_falling;
        rx_serial.value = serial_data_in;
      end
      ssm_pkg::RX_LOCAL_LOOP: begin
        rx_serial.strobe = 1'b1;
        rx_serial.value = serializer_bit;
      end
    endcase
  end

  ssm_deser #(
    .WIDTH(WB)
  ) u_deser (
    .hclk(hclk),
    .hresetn(hresetn),
    .serial_in(rx_serial),
    .double_rate(state.ctrl.double_rate_select),
    .word(rx_word),
    .word_valid(rx_word_valid),
    .par_clock(rx_par_clock)
  );

  always_comb begin
    status = '0;
    status.clock_recovered = ~bypass;
    status.tx_mode = tx_mode;
    status.rx_mode = rx_mode;
    status.tx_word = state.tx_hold;
    status.rx_word = rx_word;
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state: transmit path, loopbacks and the bus slave

  always_comb begin
    next_state = state;
    next_state.hreadyout = 1'b1;
    next_state.ref_prev = reference_clock;
    next_state.tx_clock_prev = tx_parallel_clock_in;

    // words are taken on the rising edge of the MAC's parallel clock
    if (tx_clock_rising) begin
      next_state.tx_hold = tx_data_in;
      next_state.counts.tx_words = state.counts.tx_words + 1'b1;
    end

    // 4:1 serializer, msb first; loads on bit zero of each word
    if (state.tx_bit == '0) begin
      next_state.tx_shift = state.tx_hold;
    end else begin
      next_state.tx_shift = {state.tx_shift[WB-2:0], 1'b0};
    end
    next_state.tx_bit = state.tx_bit + 1'b1;
    // low for the first half of a word so it can drive the MAC clock
    next_state.secondary_clock = (next_state.tx_bit >= HALF_BIT);

    // recovered clock and retimed data exist only while recovery runs
    next_state.rec_clock = bypass ? 1'b0 : ~state.rec_clock;
    next_state.rec_data = bypass ? 1'b0 : serial_data_in;

    unique case (tx_mode)
      ssm_pkg::TX_NORMAL: next_state.serial_out = serializer_bit;
      ssm_pkg::TX_REMOTE_SERIAL: next_state.serial_out = serial_data_in;
      ssm_pkg::TX_REMOTE_CLOCK: next_state.serial_out = state.rec_clock;
      ssm_pkg::TX_REMOTE_DATA: next_state.serial_out = state.rec_data;
    endcase

    if (rx_word_valid) begin
      next_state.counts.rx_words = state.counts.rx_words + 1'b1;
    end

    // data phase of a write; a count clear restarts at one on a same-cycle increment
    if (state.write_phase) begin
      unique case (state.data_reg)
        ssm_pkg::REG_CTRL: next_state.ctrl = hwdata[ssm_pkg::CTRL_BITS-1:0];
        ssm_pkg::REG_COUNT: begin
          next_state.counts.tx_words = tx_clock_rising ? COUNT_ONE : '0;
          next_state.counts.rx_words = rx_word_valid ? COUNT_ONE : '0;
        end
        ssm_pkg::REG_STATUS, ssm_pkg::REG_NONE: begin
        end
      endcase
    end

    // address phase; read data is ready for the data phase, zero wait states
    next_state.write_phase = 1'b0;
    if (bus_request) begin
      next_state.data_reg = decode_reg(haddr);
      next_state.write_phase = hwrite;
      if (!hwrite) begin
        unique case (decode_reg(haddr))
          ssm_pkg::REG_CTRL: next_state.hrdata = 32'(next_state.ctrl);
          ssm_pkg::REG_STATUS: next_state.hrdata = status;
          ssm_pkg::REG_COUNT: next_state.hrdata = next_state.counts;
          ssm_pkg::REG_NONE: next_state.hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
      state.ctrl <= ssm_pkg::CTRL_RESET;
      state.data_reg <= ssm_pkg::REG_NONE;
      state.hreadyout <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign hreadyout = state.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = state.hrdata;
  assign serial_data_out = state.serial_out;
  assign rx_data_out = rx_word;
  assign rx_parallel_clock_out = rx_par_clock;
  assign secondary_parallel_clock_out = state.secondary_clock;

endmodule // ssm_top

// ==== test/ssm_mac_model.sv ====
// Purpose: parallel-side MAC that feeds transmit words
// Assumes: its own transmit clock is hclk divided by four
// Notes: words change only after the clock is seen falling
`timescale 1ns/1ns

module ssm_mac_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic use_secondary,
  input wire logic [3:0] word,
  input wire logic secondary_parallel_clock_out,
  output logic tx_parallel_clock_in,
  output logic [3:0] tx_data_in
);
  logic [1:0] div;
  logic last_clock;
  // board strap: secondary clock wired back as the transmit clock
  assign tx_parallel_clock_in = use_secondary ? secondary_parallel_clock_out : div[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div <= 2'h0;
      last_clock <= 1'h0;
      tx_data_in <= 4'h0;
    end else begin
      div <= div + 2'h1;
      last_clock <= tx_parallel_clock_in;
      // change just after the fall so the word is steady at the rise
      if (last_clock && !tx_parallel_clock_in) tx_data_in <= word;
    end
  end
endmodule // ssm_mac_model

// ==== test/ssm_top_asserts.sv ====
// Purpose: port-level checks of the serdes mode and loopback block
// Assumes: the control word is shadowed from AHB-Lite writes to offset zero
// Notes: mode checks wait seven cycles after any control write
`timescale 1ns/1ns

module ssm_top_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic [ssm_pkg::WORD_BITS-1:0] rx_data_out,
  input wire logic rx_parallel_clock_out,
  input wire logic secondary_parallel_clock_out
);
  ssm_pkg::ssm_ctrl_type shadow;
  logic wr_pend, quiet, rx_norm;
  logic [2:0] settle, since_word;
  logic [1:0] rx_mode, tx_mode;
  assign rx_mode = {shadow.rx_path_select_0, shadow.rx_path_select_1};
  assign tx_mode = {shadow.tx_path_select_0, shadow.tx_path_select_1};
  // rewriting the same value also restarts the wait: costs coverage only
  assign quiet = settle == 3'h7;
  assign rx_norm = quiet && rx_mode == 2'h3 && !shadow.double_rate_select;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shadow <= ssm_pkg::CTRL_RESET;
      wr_pend <= 1'h0;
      settle <= 3'h0;
      since_word <= 3'h0;
    end else begin
      if (hready) wr_pend <= hsel && htrans[1] && hwrite && haddr == 32'h0;
      if (wr_pend && hready) begin
        shadow <= hwdata[ssm_pkg::CTRL_BITS-1:0];
        settle <= 3'h0;
      end else if (!quiet) begin
        settle <= settle + 3'h1;
      end
      if ($changed(rx_data_out)) since_word <= 3'h0;
      else if (since_word != 3'h7) since_word <= since_word + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence sec_tail_s;
    secondary_parallel_clock_out ##1 !secondary_parallel_clock_out [*2]
      ##1 secondary_parallel_clock_out;
  endsequence
  sec_clock_a: assert property ($rose(secondary_parallel_clock_out) |=> sec_tail_s)
    else $error("secondary clock not two high two low");
  rx_clock_a: assert property (rx_norm && $rose(rx_parallel_clock_out) |->
    ($past(rx_parallel_clock_out, 3) && !$past(rx_parallel_clock_out, 2))
      ##1 rx_parallel_clock_out)
    else $error("parallel clock not divide by four");
  rx_word_a: assert property (rx_norm && $changed(rx_data_out) |-> since_word >= 3'h3)
    else $error("received word changed within four bits");
  loop_serial_a: assert property (
    quiet && tx_mode == 2'h0 |-> serial_data_out == $past(serial_data_in))
    else $error("serial loopback not one cycle behind input");
  loop_data_a: assert property (
    quiet && tx_mode == 2'h1 && rx_mode != 2'h1 |-> serial_data_out == $past(serial_data_in, 2))
    else $error("recovered data loopback wrong");
  loop_clock_a: assert property (
    quiet && tx_mode == 2'h2 && rx_mode != 2'h1 |-> serial_data_out != $past(serial_data_out))
    else $error("recovered clock loopback not toggling");
  bypass_quiet_a: assert property (
    quiet && tx_mode == 2'h2 && rx_mode == 2'h1 |-> !serial_data_out)
    else $error("recovered clock present in bypass");
  ctrl_read_a: assert property (
    hsel && hready && htrans[1] && !hwrite && haddr == 32'h0 |=> hrdata == {23'h0, shadow})
    else $error("control read differs from last write");
endmodule // ssm_top_asserts

bind ssm_top ssm_top_asserts i_ssm_top_asserts (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .serial_data_in, .serial_data_out, .rx_data_out,
  .rx_parallel_clock_out, .secondary_parallel_clock_out);

// ==== test/testbench.sv ====
// Purpose: self-checking bench for the serdes mode and loopback block
// Assumes: one serial bit per hclk, word boundaries counted from reset
// Notes: line side driven here, parallel side by the MAC model
`timescale 1ns/1ns

module testbench;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, serial_data_out, rx_parallel_clock_out, secondary_parallel_clock_out;
  logic serial_data_in = 1'h0, reference_clock = 1'h0, tx_parallel_clock_in;
  logic use_secondary = 1'h0, bypass = 1'h0, bypass_bit = 1'h0;
  logic [3:0] tx_data_in, rx_data_out, mac_word = 4'hA, stream = 4'hB;
  logic [15:0] cnt = 16'h0;
  int n_fail = 0, checks_done = 0, cycles = 0;
  always #5 hclk = ~hclk;
  ssm_top i_ssm_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .serial_data_in, .reference_clock,
    .tx_parallel_clock_in, .tx_data_in, .serial_data_out, .rx_data_out,
    .rx_parallel_clock_out, .secondary_parallel_clock_out);
  ssm_mac_model i_ssm_mac_model (.hclk, .hresetn, .use_secondary, .word(mac_word),
    .secondary_parallel_clock_out, .tx_parallel_clock_in, .tx_data_in);
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt <= 16'h0;
    else cnt <= cnt + 16'h1;
  end
  // reference clock runs always; bypass data is right only at its fall
  always @(posedge hclk) begin
    reference_clock <= ((cnt + 1) % 8) < 4;
    if (bypass) serial_data_in <= (((cnt + 1) % 8) == 4) ? bypass_bit : !bypass_bit;
    else serial_data_in <= stream[3 - ((cnt + 1) % 4)];
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic [31:0] addr, input logic wr, input logic [31:0] wdata);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wdata;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  // serial bit expected from the word phase counted since reset
  // msb reaches the pin one edge after the load edge
  task automatic ser_chk(input logic [3:0] word);
    repeat (8) begin
      @(posedge hclk);
      #1;
      chk({31'h0, serial_data_out}, {31'h0, word[3 - ((cnt + 2) % 4)]});
    end
  endtask
  task automatic rx_chk(input int wait_cycles, input logic [3:0] exp);
    repeat (wait_cycles) @(posedge hclk);
    #1;
    chk({28'h0, rx_data_out}, {28'h0, exp});
  endtask
  function automatic logic [31:0] ctrl_word(input logic [1:0] rx, input logic [1:0] tx);
    return 32'h0000_0160 | {28'h0, tx[0], tx[1], rx[0], rx[1]};
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    ahb(32'h0, 1'h0, 32'h0);
    chk(rd, 32'h0000_016F);
    ahb(32'h0000_000C, 1'h0, 32'h0);
    chk(rd, 32'h0);
    rx_chk(20, 4'hB);
    ahb(32'h4, 1'h0, 32'h0);
    chk(rd, 32'h0000_1FAB);
    ser_chk(4'hA);
    use_secondary <= 1'h1;
    mac_word <= 4'h5;
    stream <= 4'h6;
    repeat (24) @(posedge hclk);
    ser_chk(4'h5);
    // each remote loopback (serial, data, clock) runs alone, without local loopback
    for (int m = 0; m < 3; m++) begin
      ahb(32'h0, 1'h1, ctrl_word(2'h3, 2'(m)));
      repeat (16) @(posedge hclk);
      ahb(32'h4, 1'h0, 32'h0);
      chk(rd & 32'h0000_1F00, {19'h0, 1'h1, 2'(m), 2'h3, 8'h0});
    end
    bypass_bit <= 1'h1;
    bypass <= 1'h1;
    ahb(32'h0, 1'h1, ctrl_word(2'h1, 2'h2));
    rx_chk(80, 4'hF);
    bypass_bit <= 1'h0;
    rx_chk(80, 4'h0);
    ahb(32'h4, 1'h0, 32'h0);
    chk(rd & 32'h0000_1F00, 32'h0000_0900);
    bypass <= 1'h0;
    stream <= 4'h0;
    mac_word <= 4'hF;
    ahb(32'h0, 1'h1, ctrl_word(2'h2, 2'h3));
    rx_chk(40, 4'hF);
    @(posedge hclk);
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    ahb(32'h0, 1'h0, 32'h0);
    chk(rd, 32'h0000_016F);
    // one tx capture and one rx word since the release
    ahb(32'h0000_0008, 1'h0, 32'h0);
    chk(rd, 32'h0001_0001);
    // clear meets an rx increment: the increment survives
    ahb(32'h0000_0008, 1'h1, 32'h0);
    ahb(32'h0000_0008, 1'h0, 32'h0);
    chk(rd, 32'h0001_0001);
    repeat (4) begin
      @(posedge hclk);
      #1;
      chk({30'h0, rx_parallel_clock_out, secondary_parallel_clock_out},
        {30'h0, {2{(cnt % 4) >= 2}}});
    end
    report_and_stop();
  end
endmodule // testbench
